// *** hdl/ssp_brg.sv ***
// Reload divider giving two ticks per serial clock period
`timescale 1ns/1ps
module ssp_brg #(
  parameter int RW = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic use_ext,
  input wire logic ext_tick,
  input wire logic [RW-1:0] reload,
  // Half-period tick
  output logic tick
);
  typedef struct packed {
    logic pre;
    logic [RW-1:0] cnt;
    logic tick;
  } ssp_brg_st_t;

  ssp_brg_st_t st_ff;
  ssp_brg_st_t nxt_st;

  // Fixed dividers need reload values up to fifteen
  if (RW < 4) begin : g_chk
    $error("ssp_brg: RW must be at least 4");
  end

  // Prescale by two, then count reload+1: half period 2*(reload+1) cycles
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (!run) begin
      nxt_st.pre = 1'b0;
      nxt_st.cnt = reload;
    end else if (use_ext) begin
      nxt_st.tick = ext_tick;
    end else begin
      nxt_st.pre = ~st_ff.pre;
      if (st_ff.pre) begin
        if (st_ff.cnt == '0) begin
          nxt_st.cnt = reload;
          nxt_st.tick = 1'b1;
        end else begin
          nxt_st.cnt = st_ff.cnt - 1'b1;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;
endmodule

// *** hdl/ssp_ctrl.sv ***
// Control and status register block of the synchronous serial port
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
module ssp_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [ssp_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ssp_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Events from the shift engine
  input wire logic eng_rx_done,
  input wire logic [7:0] eng_rx_byte,
  input wire logic eng_tx_done,
  input wire logic eng_byte_is_data,
  input wire logic eng_tx_busy,
  input wire logic eng_slave_tx_busy,
  input wire logic eng_bus_busy,
  input wire logic eng_addr_match,
  input wire logic eng_rw_bit,
  input wire logic eng_start_det,
  input wire logic eng_stop_det,
  input wire logic eng_nack_det,
  input wire logic eng_ack_valid,
  input wire logic eng_ack_bit,
  input wire logic eng_upd_addr_req,
  input wire logic eng_seq_done,
  input wire logic t2_match,
  // Pin routing
  output logic route_clk_pin,
  output logic route_data_pin,
  output logic route_ss_pin,
  // Engine controls
  output logic spi_sample_at_end,
  output logic spi_shift_on_trail,
  output logic spi_idle_high,
  output logic i2c_scl_hold,
  output logic i2c_stretch_en,
  output logic i2c_sp_irq_en,
  output logic mode_reserved,
  output logic serial_clk_tick,
  output logic port_idle,
  // Master sequence requests
  output logic start_req,
  output logic rstart_req,
  output logic stop_req,
  output logic rcv_req,
  output logic ack_req,
  output logic ack_value,
  // Buffer and events
  output logic tx_load,
  output logic [7:0] tx_data,
  output logic gen_call_irq
);
  typedef struct packed {
    logic aw_got;
    logic [2:0] aw_idx;
    logic aw_bad;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic sample_end;
    logic edge_sel;
    logic data_addr;
    logic stop_seen;
    logic start_seen;
    logic dir;
    logic upd_addr;
    logic full;
    logic coll;
    logic ovf;
    logic enable;
    logic clk_pol;
    logic [3:0] mode;
    logic gen_call_en;
    logic ack_stat;
    logic ack_val;
    logic ack_trig;
    logic rcv_trig;
    logic stop_trig;
    logic rstart_trig;
    logic start_trig;
    logic [7:0] buffer;
    logic [7:0] reload;
    logic tx_load;
    logic gc_irq;
  } ssp_ctrl_st_t;

  ssp_ctrl_st_t st_ff;
  ssp_ctrl_st_t nxt_st;

  logic spi_master, spi_slave, spi_ss_en, i2c_slave, i2c_10bit;
  logic i2c_master, i2c_hw_master, use_t2, use_brg;
  logic [7:0] fixed_reload;
  logic is_i2c, any_trig, idle, coll_hit, wr_go, wr_ok, rd_go, rd_bad;
  logic [2:0] rd_idx;
  logic [7:0] wdat, status_v, ctrl1_v, ctrl2_v, rd_mux;

  // Mode decode
  ssp_mode_dec ssp_mode_dec_inst (
    .mode(st_ff.mode),
    .spi_master(spi_master),
    .spi_slave(spi_slave),
    .spi_ss_en(spi_ss_en),
    .i2c_slave(i2c_slave),
    .i2c_10bit(i2c_10bit),
    .i2c_master(i2c_master),
    .i2c_hw_master(i2c_hw_master),
    .sp_irq_en(i2c_sp_irq_en),
    .reserved(mode_reserved),
    .use_t2(use_t2),
    .use_brg(use_brg),
    .fixed_reload(fixed_reload)
  );

  // Serial clock divider, running only for clock-making modes
  ssp_brg #(.RW(8)) ssp_brg_inst (
    .clk(clk),
    .rst(rst),
    .run(st_ff.enable && (spi_master || i2c_hw_master)),
    .use_ext(use_t2),
    .ext_tick(t2_match),
    .reload(use_brg ? st_ff.reload : fixed_reload),
    .tick(serial_clk_tick)
  );

  // Master busy view; a busy master queues nothing
  assign is_i2c = i2c_slave || i2c_master;
  assign any_trig = st_ff.ack_trig | st_ff.rcv_trig | st_ff.stop_trig
                  | st_ff.rstart_trig | st_ff.start_trig;
  assign idle = !(st_ff.dir || any_trig);
  assign coll_hit = (i2c_master && (!idle || eng_bus_busy))
                  || ((spi_slave || i2c_slave) && eng_slave_tx_busy);

  // Bus strobes; a write completes once both halves are held
  assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign wr_go = st_ff.aw_got && st_ff.w_got;
  assign wr_ok = wr_go && st_ff.w_lane && !st_ff.aw_bad;
  assign wdat = st_ff.w_data;
  assign rd_go = s_axi_arvalid && !st_ff.rvalid;
  assign rd_idx = s_axi_araddr[ssp_pkg::IDX_LSB +: ssp_pkg::IDX_W];
  assign rd_bad = (s_axi_araddr[ssp_pkg::AXI_AW-1:ssp_pkg::IDX_LSB+ssp_pkg::IDX_W] != '0)
                || (rd_idx > ssp_pkg::IDX_ADDR);

  // Register images as software sees them
  assign status_v = {st_ff.sample_end, st_ff.edge_sel, st_ff.data_addr, st_ff.stop_seen,
                     st_ff.start_seen, st_ff.dir, st_ff.upd_addr, st_ff.full};
  assign ctrl1_v = {st_ff.coll, st_ff.ovf, st_ff.enable, st_ff.clk_pol, st_ff.mode};
  assign ctrl2_v = {st_ff.gen_call_en, st_ff.ack_stat, st_ff.ack_val, st_ff.ack_trig,
                    st_ff.rcv_trig, st_ff.stop_trig, st_ff.rstart_trig, st_ff.start_trig};

  // Read multiplexer
  always_comb begin
    case (rd_idx)
      ssp_pkg::IDX_STATUS: rd_mux = status_v;
      ssp_pkg::IDX_CTRL1: rd_mux = ctrl1_v;
      ssp_pkg::IDX_CTRL2: rd_mux = ctrl2_v;
      ssp_pkg::IDX_BUF: rd_mux = st_ff.buffer;
      ssp_pkg::IDX_ADDR: rd_mux = st_ff.reload;
      default: rd_mux = ssp_pkg::REG_RESET;
    endcase
  end

  // Next state: bus, then software writes, then hardware events so hardware events win
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tx_load = 1'b0;
    nxt_st.gc_irq = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_idx = s_axi_awaddr[ssp_pkg::IDX_LSB +: ssp_pkg::IDX_W];
      nxt_st.aw_bad = (s_axi_awaddr[ssp_pkg::AXI_AW-1:ssp_pkg::IDX_LSB+ssp_pkg::IDX_W] != '0)
                    || (s_axi_awaddr[ssp_pkg::IDX_LSB +: ssp_pkg::IDX_W] > ssp_pkg::IDX_ADDR);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.w_data = s_axi_wdata[7:0];
      nxt_st.w_lane = s_axi_wstrb[0];
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (wr_go) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = st_ff.aw_bad ? ssp_pkg::RESP_SLVERR : ssp_pkg::RESP_OKAY;
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (rd_go) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd_bad ? ssp_pkg::REG_RESET : rd_mux;
      nxt_st.rresp = rd_bad ? ssp_pkg::RESP_SLVERR : ssp_pkg::RESP_OKAY;
      if (!rd_bad && rd_idx == ssp_pkg::IDX_BUF) begin
        nxt_st.full = 1'b0;
      end
    end
    if (wr_ok) begin
      case (st_ff.aw_idx)
        ssp_pkg::IDX_STATUS: begin
          nxt_st.sample_end = wdat[ssp_pkg::ST_SAMPLE];
          nxt_st.edge_sel = wdat[ssp_pkg::ST_EDGE];
        end
        ssp_pkg::IDX_CTRL1: begin
          if (!wdat[ssp_pkg::C1_COLL]) begin
            nxt_st.coll = 1'b0;
          end
          if (!wdat[ssp_pkg::C1_OVF]) begin
            nxt_st.ovf = 1'b0;
          end
          nxt_st.enable = wdat[ssp_pkg::C1_ENABLE];
          nxt_st.clk_pol = wdat[ssp_pkg::C1_CLK_POL];
          nxt_st.mode = wdat[ssp_pkg::MODE_W-1:0];
        end
        ssp_pkg::IDX_CTRL2: begin
          nxt_st.gen_call_en = wdat[ssp_pkg::C2_GEN_CALL];
          nxt_st.ack_val = wdat[ssp_pkg::C2_ACK_VAL];
          if (!i2c_master) begin
            nxt_st.start_trig = wdat[ssp_pkg::C2_START_TRIG];
          end else if (idle) begin
            nxt_st.ack_trig = wdat[ssp_pkg::C2_ACK_TRIG];
            nxt_st.rcv_trig = wdat[ssp_pkg::C2_RCV_TRIG];
            nxt_st.stop_trig = wdat[ssp_pkg::C2_STOP_TRIG];
            nxt_st.rstart_trig = wdat[ssp_pkg::C2_RSTART_TRIG];
            nxt_st.start_trig = wdat[ssp_pkg::C2_START_TRIG];
          end
        end
        ssp_pkg::IDX_BUF: begin
          if (coll_hit) begin
            nxt_st.coll = 1'b1;
          end else begin
            nxt_st.buffer = wdat;
            nxt_st.tx_load = 1'b1;
            nxt_st.full = is_i2c ? 1'b1 : nxt_st.full;
          end
        end
        ssp_pkg::IDX_ADDR: begin
          nxt_st.reload = wdat;
          nxt_st.upd_addr = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // Transmit end empties the buffer in the I2C modes
    if (eng_tx_done && is_i2c) begin
      nxt_st.full = 1'b0;
      nxt_st.data_addr = eng_byte_is_data;
    end
    // Reception: SPI master always loads, a full buffer elsewhere overflows
    if (eng_rx_done && st_ff.enable) begin
      if (spi_master || !nxt_st.full) begin
        nxt_st.buffer = eng_rx_byte;
        nxt_st.full = 1'b1;
      end else begin
        nxt_st.ovf = 1'b1;
      end
      if (is_i2c) begin
        nxt_st.data_addr = eng_byte_is_data;
      end
      if (i2c_slave && st_ff.gen_call_en && !eng_byte_is_data
          && eng_rx_byte == ssp_pkg::GEN_CALL_ADDR) begin
        nxt_st.gc_irq = 1'b1;
      end
    end
    // Bus conditions seen most recently
    if (!st_ff.enable) begin
      nxt_st.start_seen = 1'b0;
      nxt_st.stop_seen = 1'b0;
    end else if (is_i2c && eng_stop_det) begin
      nxt_st.stop_seen = 1'b1;
      nxt_st.start_seen = 1'b0;
    end else if (is_i2c && eng_start_det) begin
      nxt_st.start_seen = 1'b1;
      nxt_st.stop_seen = 1'b0;
    end
    // Direction: captured by a slave, transmit-busy for a master
    if (i2c_master) begin
      nxt_st.dir = eng_tx_busy;
    end else if (i2c_slave) begin
      if (eng_addr_match) begin
        nxt_st.dir = eng_rw_bit;
      end else if (eng_start_det || eng_stop_det || eng_nack_det) begin
        nxt_st.dir = 1'b0;
      end
    end
    if (i2c_slave && i2c_10bit && eng_upd_addr_req) begin
      nxt_st.upd_addr = 1'b1;
    end
    if (is_i2c && eng_ack_valid) begin
      nxt_st.ack_stat = eng_ack_bit;
    end
    // Finished sequence frees the master for the next trigger
    if (i2c_master && eng_seq_done) begin
      nxt_st.ack_trig = 1'b0;
      nxt_st.rcv_trig = 1'b0;
      nxt_st.stop_trig = 1'b0;
      nxt_st.rstart_trig = 1'b0;
      nxt_st.start_trig = 1'b0;
    end
  end

  // State register, all zero after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Bus answers
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = {24'h000000, st_ff.rdata};
  assign s_axi_rresp = st_ff.rresp;

  // Pins and engine controls
  assign route_clk_pin = st_ff.enable;
  assign route_data_pin = st_ff.enable;
  assign route_ss_pin = st_ff.enable && spi_ss_en;
  assign spi_sample_at_end = spi_master && st_ff.sample_end;
  assign spi_shift_on_trail = (spi_master || spi_slave) && st_ff.edge_sel;
  assign spi_idle_high = (spi_master || spi_slave) && st_ff.clk_pol;
  assign i2c_scl_hold = i2c_slave && st_ff.enable && !st_ff.clk_pol;
  assign i2c_stretch_en = i2c_slave && st_ff.start_trig;
  assign port_idle = idle;
  assign start_req = i2c_master && st_ff.start_trig;
  assign rstart_req = i2c_master && st_ff.rstart_trig;
  assign stop_req = i2c_master && st_ff.stop_trig;
  assign rcv_req = i2c_master && st_ff.rcv_trig;
  assign ack_req = i2c_master && st_ff.ack_trig;
  assign ack_value = st_ff.ack_val;
  assign tx_load = st_ff.tx_load;
  assign tx_data = st_ff.buffer;
  assign gen_call_irq = st_ff.gc_irq;

  // Checks on the control logic
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_sample_end;
    wr_ok && st_ff.aw_idx == ssp_pkg::IDX_STATUS && wdat[ssp_pkg::ST_SAMPLE] && spi_master
    |=> spi_sample_at_end;
  endproperty
  a_sample_end: assert property (p_sample_end) else $error("sample select not applied");

  property p_coll_set;
    wr_ok && st_ff.aw_idx == ssp_pkg::IDX_BUF && coll_hit |=> st_ff.coll && !tx_load;
  endproperty
  a_coll_set: assert property (p_coll_set) else $error("collision not flagged");

  property p_spi_ovf;
    eng_rx_done && st_ff.enable && spi_slave && st_ff.full
    && !(rd_go && !rd_bad && rd_idx == ssp_pkg::IDX_BUF)
    |=> st_ff.ovf && $stable(st_ff.buffer);
  endproperty
  a_spi_ovf: assert property (p_spi_ovf) else $error("slave overflow mishandled");

  property p_master_no_ovf;
    spi_master && !st_ff.ovf |=> !st_ff.ovf;
  endproperty
  a_master_no_ovf: assert property (p_master_no_ovf) else $error("master set overflow");

  property p_start_seen;
    eng_start_det && !eng_stop_det && is_i2c && st_ff.enable
    |=> st_ff.start_seen && !st_ff.stop_seen;
  endproperty
  a_start_seen: assert property (p_start_seen) else $error("start not recorded");

  property p_off_clear;
    !st_ff.enable |=> !st_ff.start_seen && !st_ff.stop_seen;
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("flags kept while disabled");

  property p_busy_hold;
    wr_ok && st_ff.aw_idx == ssp_pkg::IDX_CTRL2 && i2c_master && !idle && !eng_seq_done
    |=> $stable(ctrl2_v[ssp_pkg::C2_ACK_TRIG:0]);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("trigger queued while busy");

  property p_seq_clear;
    i2c_master && eng_seq_done |=> !any_trig;
  endproperty
  a_seq_clear: assert property (p_seq_clear) else $error("trigger not self-cleared");

  property p_gen_call;
    eng_rx_done && st_ff.enable && i2c_slave && st_ff.gen_call_en && !eng_byte_is_data
    && eng_rx_byte == ssp_pkg::GEN_CALL_ADDR |=> gen_call_irq ##1 !gen_call_irq;
  endproperty
  a_gen_call: assert property (p_gen_call) else $error("general call missed");

  property p_rx_full;
    eng_rx_done && st_ff.enable |=> st_ff.full;
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("buffer not full after receive");

  c_buf_write: cover property (tx_load);
  c_overflow: cover property ($rose(st_ff.ovf));
  c_gen_call: cover property (gen_call_irq);
  c_seq_done: cover property (start_req ##[1:50] !start_req);
endmodule

// *** hdl/ssp_mode_dec.sv ***
// Decoder of the port mode field
`timescale 1ns/1ps
module ssp_mode_dec (
  // Mode field
  input wire logic [ssp_pkg::MODE_W-1:0] mode,
  // Decoded roles
  output logic spi_master,
  output logic spi_slave,
  output logic spi_ss_en,
  output logic i2c_slave,
  output logic i2c_10bit,
  output logic i2c_master,
  output logic i2c_hw_master,
  output logic sp_irq_en,
  output logic reserved,
  // Clock source
  output logic use_t2,
  output logic use_brg,
  output logic [7:0] fixed_reload
);
  // One case per code; reserved codes leave every role off
  always_comb begin
    spi_master = 1'b0;
    spi_slave = 1'b0;
    spi_ss_en = 1'b0;
    i2c_slave = 1'b0;
    i2c_10bit = 1'b0;
    i2c_master = 1'b0;
    i2c_hw_master = 1'b0;
    sp_irq_en = 1'b0;
    reserved = 1'b0;
    use_t2 = 1'b0;
    use_brg = 1'b0;
    fixed_reload = ssp_pkg::DIV4_RELOAD;
    case (mode)
      ssp_pkg::M_SPI_M4: spi_master = 1'b1;
      ssp_pkg::M_SPI_M16: begin
        spi_master = 1'b1;
        fixed_reload = ssp_pkg::DIV16_RELOAD;
      end
      ssp_pkg::M_SPI_M64: begin
        spi_master = 1'b1;
        fixed_reload = ssp_pkg::DIV64_RELOAD;
      end
      ssp_pkg::M_SPI_T2: begin
        spi_master = 1'b1;
        use_t2 = 1'b1;
      end
      ssp_pkg::M_SPI_BRG: begin
        spi_master = 1'b1;
        use_brg = 1'b1;
      end
      ssp_pkg::M_SPI_SS: begin
        spi_slave = 1'b1;
        spi_ss_en = 1'b1;
      end
      ssp_pkg::M_SPI_NOSS: spi_slave = 1'b1;
      ssp_pkg::M_I2C_S7: i2c_slave = 1'b1;
      ssp_pkg::M_I2C_S10: begin
        i2c_slave = 1'b1;
        i2c_10bit = 1'b1;
      end
      ssp_pkg::M_I2C_S7I: begin
        i2c_slave = 1'b1;
        sp_irq_en = 1'b1;
      end
      ssp_pkg::M_I2C_S10I: begin
        i2c_slave = 1'b1;
        i2c_10bit = 1'b1;
        sp_irq_en = 1'b1;
      end
      ssp_pkg::M_I2C_HWM: begin
        i2c_master = 1'b1;
        i2c_hw_master = 1'b1;
        use_brg = 1'b1;
      end
      ssp_pkg::M_I2C_FWM: i2c_master = 1'b1;
      default: reserved = 1'b1;
    endcase
  end
endmodule

// *** hdl/ssp_pkg.sv ***
// Package: register map, field positions and mode codes of the serial port
package ssp_pkg;
  // Bus shape and answers
  localparam int AXI_AW = 8;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register word indices
  localparam logic [2:0] IDX_STATUS = 3'h0;
  localparam logic [2:0] IDX_CTRL1 = 3'h1;
  localparam logic [2:0] IDX_CTRL2 = 3'h2;
  localparam logic [2:0] IDX_BUF = 3'h3;
  localparam logic [2:0] IDX_ADDR = 3'h4;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Status and control one bits
  localparam int ST_SAMPLE = 7;
  localparam int ST_EDGE = 6;
  localparam int C1_COLL = 7;
  localparam int C1_OVF = 6;
  localparam int C1_ENABLE = 5;
  localparam int C1_CLK_POL = 4;
  localparam int MODE_W = 4;
  // Control two bits
  localparam int C2_GEN_CALL = 7;
  localparam int C2_ACK_VAL = 5;
  localparam int C2_ACK_TRIG = 4;
  localparam int C2_RCV_TRIG = 3;
  localparam int C2_STOP_TRIG = 2;
  localparam int C2_RSTART_TRIG = 1;
  localparam int C2_START_TRIG = 0;
  // Mode codes
  localparam logic [3:0] M_SPI_M4 = 4'h0;
  localparam logic [3:0] M_SPI_M16 = 4'h1;
  localparam logic [3:0] M_SPI_M64 = 4'h2;
  localparam logic [3:0] M_SPI_T2 = 4'h3;
  localparam logic [3:0] M_SPI_SS = 4'h4;
  localparam logic [3:0] M_SPI_NOSS = 4'h5;
  localparam logic [3:0] M_I2C_S7 = 4'h6;
  localparam logic [3:0] M_I2C_S10 = 4'h7;
  localparam logic [3:0] M_I2C_HWM = 4'h8;
  localparam logic [3:0] M_SPI_BRG = 4'hA;
  localparam logic [3:0] M_I2C_FWM = 4'hB;
  localparam logic [3:0] M_I2C_S7I = 4'hE;
  localparam logic [3:0] M_I2C_S10I = 4'hF;
  // Half-period reloads for the fixed dividers 4, 16 and 64
  localparam logic [7:0] DIV4_RELOAD = 8'h00;
  localparam logic [7:0] DIV16_RELOAD = 8'h03;
  localparam logic [7:0] DIV64_RELOAD = 8'h0F;
  localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
endpackage

// *** tb/ssp_eng_model.sv ***
// Shift engine stand-in that raises one event pulse per command
`timescale 1ns/1ps
module ssp_eng_model (
  // Clock, reset and command
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] cmd,
  input wire logic [7:0] byte_in,
  // Event pulses and received byte
  output logic [7:0] ev,
  output logic [7:0] rx_byte
);
  // Byte lines flip when not valid, so a stale byte never reads as good data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev <= 8'h00;
      rx_byte <= 8'h00;
    end else begin
      ev <= (cmd == 4'h0) ? 8'h00 : 8'h01 << (cmd - 4'h1);
      rx_byte <= (cmd == 4'h1) ? byte_in : ~rx_byte;
    end
  end
endmodule

// *** tb/sync_serial_port_ctrl_status_tb.sv ***
// Self-checking bench of the serial port register block
`timescale 1ns/1ps
module sync_serial_port_ctrl_status_tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [7:0] b = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, dat = 1'h0, bbusy = 1'h0;
  logic gci, gcs = 1'h0;
  logic [3:0] cmd = 4'h0;
  logic [7:0] ev, rxb;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic route_clk_pin, route_ss_pin, mode_reserved, port_idle, start_req, ack_req, ack_value;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic [41:0] q[$];
  logic [41:0] e;
  int num_errors = 0, n_tests = 0, cyc = 0, seed = 32'h00BBB3B5;
  always #50 clk = ~clk;
  ssp_eng_model ssp_eng_model_inst (.clk, .rst, .cmd, .byte_in(b), .ev, .rx_byte(rxb));
  ssp_ctrl ssp_ctrl_inst (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp(), .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .eng_rx_done(ev[0]), .eng_rx_byte(rxb),
    .eng_tx_done(1'h0), .eng_byte_is_data(dat), .eng_tx_busy(1'h0), .eng_slave_tx_busy(1'h0),
    .eng_bus_busy(bbusy), .eng_addr_match(ev[1]), .eng_rw_bit(ev[1]), .eng_start_det(ev[2]),
    .eng_stop_det(ev[3]), .eng_nack_det(ev[7]), .eng_ack_valid(ev[5]), .eng_ack_bit(ev[5]),
    .eng_upd_addr_req(ev[6]), .eng_seq_done(ev[4]), .t2_match(1'h0), .route_clk_pin,
    .route_data_pin(), .route_ss_pin, .spi_sample_at_end(), .spi_shift_on_trail(),
    .spi_idle_high(), .i2c_scl_hold(), .i2c_stretch_en(), .i2c_sp_irq_en(), .mode_reserved,
    .serial_clk_tick(), .port_idle, .start_req, .rstart_req(), .stop_req(), .rcv_req(),
    .ack_req, .ack_value, .tx_load(), .tx_data(), .gen_call_irq(gci));
  // The general call pulse lasts one cycle, so it is latched for a later check
  always @(posedge clk) begin
    if (gci) gcs <= 1'h1;
  end
  // Compare and count
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write: ready is judged mid-cycle, each half released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge clk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end while ((s_axi_awvalid && !ta) || (s_axi_wvalid && !tw));
    do @(negedge clk); while (!s_axi_bvalid);
    @(posedge clk);
    s_axi_bready <= 1'h0;
  endtask
  // Read: the expected answer is noted before the request goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
    q.push_back({(a > 8'h10) ? ssp_pkg::RESP_SLVERR : ssp_pkg::RESP_OKAY, m, 24'h0, x});
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(negedge clk); while (!s_axi_arready);
    @(posedge clk);
    s_axi_arvalid <= 1'h0;
    do @(negedge clk); while (!s_axi_rvalid);
    @(posedge clk);
    s_axi_rready <= 1'h0;
  endtask
  // One engine command, held for a single cycle
  task automatic evt(input logic [3:0] c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= 4'h0;
  endtask
  // Read answers are matched against the oldest note
  always @(negedge clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      e = q.pop_front();
      chk({s_axi_rresp, s_axi_rdata & {24'hFFFFFF, e[39:32]}}, {e[41:40], e[31:0]});
    end
  end
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      final_report();
    end
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 8'h00, 8'hFF);
    wr(8'h10, 8'h03);
    wr(8'h04, 8'h26);
    chk(34'(route_clk_pin), 34'h1);
    wr(8'h00, 8'h7F);
    rd(8'h00, 8'h40, 8'hFF);
    dat <= 1'h1;
    b <= 8'($random(seed));
    evt(4'h1);
    b <= ~b;
    evt(4'h1);
    rd(8'h00, 8'h61, 8'hFF);
    rd(8'h04, 8'h66, 8'hFF);
    rd(8'h0C, ~b, 8'hFF);
    evt(4'h3);
    rd(8'h00, 8'h08, 8'h18);
    evt(4'h4);
    rd(8'h00, 8'h10, 8'h18);
    evt(4'h2);
    rd(8'h00, 8'h04, 8'h04);
    wr(8'h04, 8'h06);
    rd(8'h00, 8'h00, 8'h18);
    rd(8'h04, 8'h06, 8'hFF);
    chk(34'(route_clk_pin), 34'h0);
    wr(8'h04, 8'h28);
    wr(8'h08, 8'h01);
    chk(34'({start_req, port_idle}), 34'h2);
    wr(8'h08, 8'h04);
    bbusy <= 1'h1;
    wr(8'h0C, b);
    bbusy <= 1'h0;
    rd(8'h08, 8'h01, 8'hFF);
    rd(8'h04, 8'hA8, 8'hFF);
    evt(4'h5);
    rd(8'h08, 8'h00, 8'hFF);
    evt(4'h6);
    rd(8'h08, 8'h40, 8'hFF);
    wr(8'h08, 8'h30);
    chk(34'({ack_req, ack_value}), 34'h3);
    for (int m = 0; m < 16; m++) begin
      wr(8'h04, 8'(8'h20 + m));
      chk(34'({mode_reserved, route_ss_pin}), 34'({m == 9 || m == 12 || m == 13, m == 4}));
    end
    wr(8'h04, 8'h27);
    wr(8'h08, 8'h80);
    dat <= 1'h0;
    b <= ssp_pkg::GEN_CALL_ADDR;
    evt(4'h1);
    evt(4'h7);
    rd(8'h00, 8'h03, 8'h23);
    chk(34'(gcs), 34'h1);
    wr(8'h10, 8'h05);
    rd(8'h00, 8'h01, 8'h03);
    final_report();
  end
endmodule
